// [uart_loop_defs.svh]
`ifndef UART_LOOP_DEFS_SVH
`define UART_LOOP_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_CONTROL_ONE 8'h42
`define OFS_CONTROL_TWO 8'h43
`define OFS_STATUS      8'h44
`define OFS_DATA_HI     8'h46
`define OFS_DATA_LO     8'h47

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define C1_LOOP_BIT     7
`define C1_RECEIVER_SOURCE_SELECT_BIT     5
`define C1_NINE_BIT     4
`define C1_ILT_BIT      2
`define C1_PAR_ON_BIT   1
`define C1_PAR_ODD_BIT  0
`define C1_WR_MASK      8'hB7
`define C2_TIE_BIT      7
`define C2_TX_DONE_IRQ_EN_BIT     6
`define C2_RIE_BIT      5
`define C2_TE_BIT       3
`define C2_RE_BIT       2
`define C1_RESET        8'h00
`define C2_RESET        8'h00

// ****************************************************************
// Timing and frame lengths
// ****************************************************************
`define BIT_CYCLES      5'h10
`define HALF_BIT        5'h08
`define FRAME_BITS_8    4'hA
`define FRAME_BITS_9    4'hB
`define IDLE_BITS_8     4'hA
`define IDLE_BITS_9     4'hB

`endif

// [uart_loop_pkg.sv]
package uart_loop_pkg;

   // Transmitter states
   typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;

   // Receiver states
   typedef enum logic [1:0] {RX_WAIT, RX_START, RX_DATA, RX_STOP} rx_state_t;

   // One received character
   typedef struct packed {
      logic [8:0] data;       // Data bits, bit 8 only in nine-bit mode
      logic       stop_ok;    // Stop bit seen high
   } rx_frame_t;

   // Even-parity sum of the data bits below the parity position
   function automatic logic low_parity(input logic [8:0] d, input logic nine);
      low_parity = nine ? ^d[7:0] : ^d[6:0];
   endfunction : low_parity

   // Even-parity sum of all used data bits
   function automatic logic all_parity(input logic [8:0] d, input logic nine);
      all_parity = nine ? ^d[8:0] : ^d[7:0];
   endfunction : all_parity

endpackage : uart_loop_pkg

// [rx_deframer.sv]
`timescale 1ns/10ps
`include "uart_loop_defs.svh"

module rx_deframer (
   input  wire logic                    clk_i,      // Bus clock
   input  wire logic                    rst_n_i,    // Async reset, low
   input  wire logic                    line_i,     // Selected receive line
   input  wire logic                    rx_on_i,    // Receiver enable
   input  wire logic                    nine_i,     // Nine data bits
   input  wire logic                    idle_type_i,// Idle count after stop
   output uart_loop_pkg::rx_frame_t     frame_o,    // Last character
   output logic                         done_o,     // Character done pulse
   output logic                         idle_o      // Idle line pulse
);

   // ****************************************************************
   // Frame sampling
   // ****************************************************************
   uart_loop_pkg::rx_state_t st_reg, st_next;      // Receiver state
   logic [4:0]               cyc_reg, cyc_next;    // Cycles in bit
   logic [3:0]               bit_reg, bit_next;    // Data bits taken
   logic [8:0]               sh_reg, sh_next;      // Data shifter
   uart_loop_pkg::rx_frame_t fr_reg, fr_next;      // Held character
   logic                     done_reg, done_next;  // Done pulse

   // Next frame state
   always_comb begin
      st_next   = st_reg;
      cyc_next  = cyc_reg + 5'h01;
      bit_next  = bit_reg;
      sh_next   = sh_reg;
      fr_next   = fr_reg;
      done_next = 1'b0;
      unique case (st_reg)
         uart_loop_pkg::RX_WAIT: begin
            cyc_next = 5'h00;
            if (rx_on_i && !line_i) begin
               st_next = uart_loop_pkg::RX_START;   // Falling edge seen
            end
         end
         uart_loop_pkg::RX_START: begin
            if (cyc_reg == `HALF_BIT - 5'h01) begin
               cyc_next = 5'h00;
               bit_next = 4'h0;
               // Glitch shorter than half a bit is dropped
               st_next  = line_i ? uart_loop_pkg::RX_WAIT : uart_loop_pkg::RX_DATA;
            end
         end
         uart_loop_pkg::RX_DATA: begin
            if (cyc_reg == `BIT_CYCLES - 5'h01) begin
               cyc_next = 5'h00;
               // LSB first: shift in at the top
               sh_next  = nine_i ? {line_i, sh_reg[8:1]} : {1'b0, line_i, sh_reg[7:1]};
               bit_next = bit_reg + 4'h1;
               if (bit_reg == (nine_i ? 4'h8 : 4'h7)) begin
                  st_next = uart_loop_pkg::RX_STOP;
               end
            end
         end
         uart_loop_pkg::RX_STOP: begin
            if (cyc_reg == `BIT_CYCLES - 5'h01) begin
               fr_next.data    = sh_reg;
               fr_next.stop_ok = line_i;
               done_next       = 1'b1;
               st_next         = uart_loop_pkg::RX_WAIT;
            end
         end
      endcase
   end

   // Frame registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg   <= uart_loop_pkg::RX_WAIT;
         cyc_reg  <= 5'h00;
         bit_reg  <= 4'h0;
         sh_reg   <= 9'h000;
         fr_reg   <= '0;
         done_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         cyc_reg  <= cyc_next;
         bit_reg  <= bit_next;
         sh_reg   <= sh_next;
         fr_reg   <= fr_next;
         done_reg <= done_next;
      end
   end

   // ****************************************************************
   // Idle line counting
   // ****************************************************************
   logic [4:0] icyc_reg, icyc_next;    // Cycles of high in bit
   logic [3:0] ibit_reg, ibit_next;    // Whole high bit times
   logic       arm_reg, arm_next;      // Idle may still be reported
   logic       idle_reg, idle_next;    // Idle pulse

   // High time counts from the start bit, or only after the stop bit
   always_comb begin
      icyc_next = icyc_reg;
      ibit_next = ibit_reg;
      arm_next  = arm_reg;
      idle_next = 1'b0;
      if (!line_i || (idle_type_i && st_reg != uart_loop_pkg::RX_WAIT)) begin
         icyc_next = 5'h00;
         ibit_next = 4'h0;
         if (!line_i) begin
            arm_next = 1'b1;
         end
      end else if (icyc_reg == `BIT_CYCLES - 5'h01) begin
         icyc_next = 5'h00;
         if (ibit_reg != 4'hF) begin
            ibit_next = ibit_reg + 4'h1;
         end
      end else begin
         icyc_next = icyc_reg + 5'h01;
      end
      if (arm_reg && rx_on_i && ibit_reg >= (nine_i ? `IDLE_BITS_9 : `IDLE_BITS_8)) begin
         idle_next = 1'b1;
         arm_next  = 1'b0;
      end
   end

   // Idle registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         icyc_reg <= 5'h00;
         ibit_reg <= 4'h0;
         arm_reg  <= 1'b0;
         idle_reg <= 1'b0;
      end else begin
         icyc_reg <= icyc_next;
         ibit_reg <= ibit_next;
         arm_reg  <= arm_next;
         idle_reg <= idle_next;
      end
   end

   assign frame_o = fr_reg;
   assign done_o  = done_reg;
   assign idle_o  = idle_reg;

   // Done is a single-cycle pulse
   property p_done_pulse;
      @(posedge clk_i) disable iff (!rst_n_i) done_reg |=> !done_reg;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done held two cycles");

endmodule : rx_deframer

// [uart_frame_loop_irq_control.sv]
`timescale 1ns/10ps
`include "uart_loop_defs.svh"

module uart_frame_loop_irq_control (
   input  wire logic        clk_i,        // Bus clock, 100 MHz
   input  wire logic        rst_n_i,      // Async reset, low
   input  wire logic [7:0]  addr_i,       // Register offset
   input  wire logic        wr_i,         // Write strobe
   input  wire logic        rd_i,         // Read strobe
   input  wire logic [7:0]  wr_data_i,    // Write data
   output logic      [7:0]  rd_data_o,    // Read data, one cycle later
   input  wire logic        rxd_i,        // Receive pin
   input  wire logic        txd_i,        // Transmit pin level in
   output logic             txd_o,        // Transmit pin drive
   output logic             txd_oe_o,     // Transmit pin enable, high drives
   output logic             irq_o         // Interrupt request level
);

   // ****************************************************************
   // Register port
   // ****************************************************************
   logic [7:0] c1_reg, c1_next;            // control_one
   logic [7:0] c2_reg, c2_next;            // control_two
   logic [8:0] txd_reg, txd_next;          // Transmit data buffer
   logic [7:0] rdo_reg, rdo_next;          // Read data holder
   logic       tx_buffer_empty_flag_reg, tx_buffer_empty_flag_next;        // tx_buffer_empty_flag
   logic       tc_reg, tc_next;            // tx_done_flag
   logic       rx_full_flag_reg, rx_full_flag_next;        // rx_full_flag
   logic       idle_reg, idle_next;        // Idle flag
   logic       fe_reg, fe_next;            // Framing error flag
   logic       pf_reg, pf_next;            // Parity error flag
   logic [8:0] rxb_reg, rxb_next;          // Receive data buffer

   // Control fields
   logic loop_select, receiver_source_select, nine_bit, idle_count_type;
   logic parity_on, parity_odd_select;
   logic tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, transmit_on, rx_on;
   assign loop_select            = c1_reg[`C1_LOOP_BIT];
   assign receiver_source_select = c1_reg[`C1_RECEIVER_SOURCE_SELECT_BIT];
   assign nine_bit               = c1_reg[`C1_NINE_BIT];
   assign idle_count_type        = c1_reg[`C1_ILT_BIT];
   assign parity_on              = c1_reg[`C1_PAR_ON_BIT];
   assign parity_odd_select      = c1_reg[`C1_PAR_ODD_BIT];
   assign tx_empty_irq_en        = c2_reg[`C2_TIE_BIT];
   assign tx_done_irq_en         = c2_reg[`C2_TX_DONE_IRQ_EN_BIT];
   assign rx_full_irq_en         = c2_reg[`C2_RIE_BIT];
   assign transmit_on            = c2_reg[`C2_TE_BIT];
   assign rx_on                  = c2_reg[`C2_RE_BIT];

   // Strobes decoded from the offset
   logic wr_data_lo, rd_data_lo;
   assign wr_data_lo = wr_i && addr_i == `OFS_DATA_LO;
   assign rd_data_lo = rd_i && addr_i == `OFS_DATA_LO;

   // Engine events
   logic                     tx_load;      // Buffer moved into shifter
   logic                     tx_end;       // Last bit finished
   logic                     rx_done;      // Character received
   logic                     rx_idle;      // Idle line seen
   uart_loop_pkg::rx_frame_t rx_frame;     // Received character

   // ****************************************************************
   // Register and flag update
   // ****************************************************************
   always_comb begin
      c1_next   = c1_reg;
      c2_next   = c2_reg;
      txd_next  = txd_reg;
      rdo_next  = rdo_reg;
      tx_buffer_empty_flag_next = tx_buffer_empty_flag_reg;
      tc_next   = tc_reg;
      rx_full_flag_next = rx_full_flag_reg;
      idle_next = idle_reg;
      fe_next   = fe_reg;
      pf_next   = pf_reg;
      rxb_next  = rxb_reg;
      // Writes, never blocked
      if (wr_i) begin
         unique case (addr_i)
            `OFS_CONTROL_ONE: c1_next = wr_data_i & `C1_WR_MASK;
            `OFS_CONTROL_TWO: c2_next = wr_data_i;
            `OFS_DATA_HI:     txd_next[8] = wr_data_i[0];
            `OFS_DATA_LO: begin
               txd_next[7:0] = wr_data_i;
               tx_buffer_empty_flag_next     = 1'b0;
               tc_next       = 1'b0;
            end
            default: ;                               // Unmapped: ignored
         endcase
      end
      // Reads; unmapped offsets read zero
      if (rd_i) begin
         unique case (addr_i)
            `OFS_CONTROL_ONE: rdo_next = c1_reg;
            `OFS_CONTROL_TWO: rdo_next = c2_reg;
            `OFS_STATUS:      rdo_next = {tx_buffer_empty_flag_reg, tc_reg, rx_full_flag_reg, idle_reg, 2'b00, fe_reg, pf_reg};
            `OFS_DATA_HI:     rdo_next = {7'h00, rxb_reg[8]};
            `OFS_DATA_LO:     rdo_next = rxb_reg[7:0];
            default:          rdo_next = 8'h00;
         endcase
      end
      // Reading received data empties the buffer and its errors
      if (rd_data_lo) begin
         rx_full_flag_next = 1'b0;
         idle_next = 1'b0;
         fe_next   = 1'b0;
         pf_next   = 1'b0;
      end
      // Hardware sets win over software clears
      if (tx_load) begin
         tx_buffer_empty_flag_next = 1'b1;
      end
      if (tx_end && (tx_buffer_empty_flag_reg || tx_load)) begin
         tc_next = 1'b1;
      end
      if (rx_done) begin
         rx_full_flag_next = 1'b1;
         rxb_next  = rx_frame.data;
         fe_next   = fe_next | !rx_frame.stop_ok;
         // Sum of ones including parity must match the type
         pf_next   = pf_next | (parity_on &&
                     (uart_loop_pkg::all_parity(rx_frame.data, nine_bit) != parity_odd_select));
      end
      if (rx_idle) begin
         idle_next = 1'b1;
      end
   end

   // Register file storage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         c1_reg   <= `C1_RESET;
         c2_reg   <= `C2_RESET;
         txd_reg  <= 9'h000;
         rdo_reg  <= 8'h00;
         tx_buffer_empty_flag_reg <= 1'b1;
         tc_reg   <= 1'b1;
         rx_full_flag_reg <= 1'b0;
         idle_reg <= 1'b0;
         fe_reg   <= 1'b0;
         pf_reg   <= 1'b0;
         rxb_reg  <= 9'h000;
      end else begin
         c1_reg   <= c1_next;
         c2_reg   <= c2_next;
         txd_reg  <= txd_next;
         rdo_reg  <= rdo_next;
         tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_next;
         tc_reg   <= tc_next;
         rx_full_flag_reg <= rx_full_flag_next;
         idle_reg <= idle_next;
         fe_reg   <= fe_next;
         pf_reg   <= pf_next;
         rxb_reg  <= rxb_next;
      end
   end

   // ****************************************************************
   // Transmitter
   // ****************************************************************
   uart_loop_pkg::tx_state_t ts_reg, ts_next;      // Transmit state
   logic [10:0]              sh_reg, sh_next;      // Frame shifter
   logic [4:0]               cyc_reg, cyc_next;    // Cycles in bit
   logic [3:0]               left_reg, left_next;  // Bits still to send
   logic [8:0]               tx_word;              // Data with parity placed

   // Top data bit replaced by the parity bit when parity is on
   always_comb begin
      tx_word = txd_reg;
      if (parity_on) begin
         if (nine_bit) begin
            tx_word[8] = uart_loop_pkg::low_parity(txd_reg, 1'b1) ^ parity_odd_select;
         end else begin
            tx_word[7] = uart_loop_pkg::low_parity(txd_reg, 1'b0) ^ parity_odd_select;
         end
      end
   end

   assign tx_load = ts_reg == uart_loop_pkg::TX_IDLE && transmit_on && !tx_buffer_empty_flag_reg;
   assign tx_end  = ts_reg == uart_loop_pkg::TX_SHIFT && cyc_reg == `BIT_CYCLES - 5'h01
                    && left_reg == 4'h1;

   // Shifter next state; a frame in flight finishes after disable
   always_comb begin
      ts_next   = ts_reg;
      sh_next   = sh_reg;
      cyc_next  = cyc_reg;
      left_next = left_reg;
      unique case (ts_reg)
         uart_loop_pkg::TX_IDLE: begin
            if (tx_load) begin
               ts_next   = uart_loop_pkg::TX_SHIFT;
               cyc_next  = 5'h00;
               // Start, data LSB first, optional ninth, stop
               sh_next   = nine_bit ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
               left_next = nine_bit ? `FRAME_BITS_9 : `FRAME_BITS_8;
            end
         end
         uart_loop_pkg::TX_SHIFT: begin
            cyc_next = cyc_reg + 5'h01;
            if (cyc_reg == `BIT_CYCLES - 5'h01) begin
               cyc_next  = 5'h00;
               sh_next   = {1'b1, sh_reg[10:1]};
               left_next = left_reg - 4'h1;
               if (left_reg == 4'h1) begin
                  ts_next = uart_loop_pkg::TX_IDLE;
               end
            end
         end
      endcase
   end

   // Shifter registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ts_reg   <= uart_loop_pkg::TX_IDLE;
         sh_reg   <= 11'h7FF;
         cyc_reg  <= 5'h00;
         left_reg <= 4'h0;
      end else begin
         ts_reg   <= ts_next;
         sh_reg   <= sh_next;
         cyc_reg  <= cyc_next;
         left_reg <= left_next;
      end
   end

   // ****************************************************************
   // Line routing
   // ****************************************************************
   logic tx_line;                          // Transmitter output level
   logic rx_line;                          // Receiver input level
   assign tx_line = ts_reg == uart_loop_pkg::TX_SHIFT ? sh_reg[0] : 1'b1;

   // Pin selection by loop and source select
   always_comb begin
      if (!loop_select) begin
         rx_line = rxd_i;
      end else if (!receiver_source_select) begin
         rx_line = tx_line;
      end else begin
         rx_line = txd_i;
      end
   end

   assign txd_o    = tx_line;
   assign txd_oe_o = transmit_on || ts_reg == uart_loop_pkg::TX_SHIFT;
   assign rd_data_o = rdo_reg;

   // One level from every enabled flag
   assign irq_o = (tx_empty_irq_en && tx_buffer_empty_flag_reg) ||
                  (tx_done_irq_en && tc_reg) ||
                  (rx_full_irq_en && rx_full_flag_reg);

   // ****************************************************************
   // Receiver
   // ****************************************************************
   rx_deframer u_rx (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .line_i      (rx_line),
      .rx_on_i     (rx_on),
      .nine_i      (nine_bit),
      .idle_type_i (idle_count_type),
      .frame_o     (rx_frame),
      .done_o      (rx_done),
      .idle_o      (rx_idle)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_loop_route;
      @(posedge clk_i) disable iff (!rst_n_i)
         loop_select && !receiver_source_select |-> rx_line == txd_o;
   endproperty
   a_loop_route: assert property (p_loop_route) else $error("loop path not internal");

   property p_start_bit;
      @(posedge clk_i) disable iff (!rst_n_i) tx_load |=> !txd_o [*8];
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit not low");

   property p_load_seq;
      @(posedge clk_i) disable iff (!rst_n_i)
         wr_data_lo && transmit_on && ts_reg == uart_loop_pkg::TX_IDLE |=> !tx_buffer_empty_flag_reg ##1 tx_buffer_empty_flag_reg;
   endproperty
   a_load_seq: assert property (p_load_seq) else $error("buffer not moved to shifter");

   property p_tx_off;
      @(posedge clk_i) disable iff (!rst_n_i)
         !transmit_on && ts_reg == uart_loop_pkg::TX_IDLE |=> ts_reg == uart_loop_pkg::TX_IDLE;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmitter started while off");

   property p_empty_irq;
      @(posedge clk_i) disable iff (!rst_n_i) tx_empty_irq_en && tx_buffer_empty_flag_reg |-> irq_o;
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty interrupt missing");

   property p_irq_masked;
      @(posedge clk_i) disable iff (!rst_n_i) !tx_empty_irq_en && !tx_done_irq_en && !rx_full_irq_en |-> !irq_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt while all disabled");

   property p_c2_write;
      @(posedge clk_i) disable iff (!rst_n_i)
         wr_i && addr_i == `OFS_CONTROL_TWO |=> c2_reg == $past(wr_data_i);
   endproperty
   a_c2_write: assert property (p_c2_write) else $error("control two write lost");

   property p_rx_full;
      @(posedge clk_i) disable iff (!rst_n_i) rx_done |=> rx_full_flag_reg && (rx_full_irq_en -> irq_o);
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("receive full not raised");

   property p_tc_end;
      @(posedge clk_i) disable iff (!rst_n_i) tx_end && tx_buffer_empty_flag_reg |=> tc_reg;
   endproperty
   a_tc_end: assert property (p_tc_end) else $error("transmit done not set");

endmodule : uart_frame_loop_irq_control

// [serial_node_model.sv]
`timescale 1ns/10ps

// Remote node: sends one frame LSB first, 16 clocks a bit, line idles high
module serial_node_model (
   input  wire logic        clk_i,  // Bus clock
   input  wire logic        go_i,   // Start a frame
   input  wire logic [11:0] bits_i, // Start bit first, ones after stop
   output logic             line_o  // Serial line, pulled high
);
   logic [11:0] sh_reg;          // Bits still to send
   logic [7:0]  cnt_reg = 8'h00; // Clocks left in the frame

   // Load on go, shift one bit every bit time
   always @(posedge clk_i) begin
      if (go_i) begin
         sh_reg  <= bits_i;
         cnt_reg <= 8'hC0;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
         if (cnt_reg[3:0] == 4'h1) sh_reg <= {1'b1, sh_reg[11:1]};
      end
   end

   assign line_o = (cnt_reg != 8'h00) ? sh_reg[0] : 1'b1; // Pull-up when idle
endmodule : serial_node_model

// [uart_frame_loop_irq_control_test.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module uart_frame_loop_irq_control_test;
   // ****************************************************************
   // Stimulus and model state
   // ****************************************************************
   logic        clk_i     = 1'b0;  // Bus clock
   logic        rst_n_i   = 1'b0;  // Reset, low
   logic [7:0]  addr_i    = 8'h00; // Offset
   logic        wr_i      = 1'b0;  // Write strobe
   logic        rd_i      = 1'b0;  // Read strobe
   logic [7:0]  wr_data_i = 8'h00; // Write data
   logic [7:0]  rd_data_o;         // Read data
   logic        txd_o, txd_oe_o, irq_o, line;
   logic        go        = 1'b0;  // Partner start
   logic [7:0]  m         = 8'h00; // Current control_one
   logic [11:0] bits      = 12'hFFF;
   logic [8:0]  x;                 // Expected character
   logic [7:0]  d, e, h, v;        // Stimulus bytes
   logic [7:0]  modes [8] = '{8'h80, 8'h83, 8'h82, 8'h90, 8'h93, 8'h04, 8'h20, 8'hA0};
   integer      n_mismatch = 0, n_compared = 0, seed = 89, i;

   always #5 clk_i = ~clk_i;

   // Single wire takes the partner on txd; rxd then carries an inverted copy
   uart_frame_loop_irq_control u_uart_frame_loop_irq_control (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
      .rxd_i(line ^ (m == 8'hA0)), .txd_i(txd_oe_o ? txd_o : ((m == 8'hA0) ? line : 1'b1)),
      .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o));
   serial_node_model u_serial_node_model (.clk_i(clk_i), .go_i(go), .bits_i(bits), .line_o(line));

   // ****************************************************************
   // Bus tasks and verdict
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(negedge clk_i);
      wr_i      = 1'b1;
      addr_i    = a;
      wr_data_i = w;
      @(negedge clk_i);
      wr_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(negedge clk_i);
      rd_i   = 1'b1;
      addr_i = a;
      @(negedge clk_i);
      rd_i = 1'b0;
      r    = rd_data_o;
   endtask : rd

   task automatic report_and_stop;
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      rd(8'h43, v);
      `CHK("control_two", 8'h00, v)
      rd(8'h44, v);
      `CHK("status", 8'hC0, v)
      // Each interrupt enable alone, then a random pattern
      for (i = 0; i < 4; i++) begin
         v = (i < 3) ? (8'h80 >> i) : $random(seed);
         wr(8'h43, v);
         rd(8'h43, h);
         `CHK("control_two", v, h)
         `CHK("irq", v[7] | v[6], irq_o)
         `CHK("txd_oe", v[3], txd_oe_o)
      end
      // Every routing mode and several formats, partner talking on rxd meanwhile
      for (int k = 0; k < 8; k++) begin
         m = modes[k];
         wr(8'h43, 8'h00);
         wr(8'h42, m);
         wr(8'h43, (m[7] && !m[5]) ? 8'h2C : 8'h24);
         d    = $random(seed);
         e    = $random(seed);
         h    = $random(seed);
         x    = {1'b0, e};
         bits = {3'h7, e, 1'b0};
         go   = 1'b1;
         @(negedge clk_i);
         go = 1'b0;
         // Data is written in every mode; with the transmitter off it must wait
         if (m[7] && !m[5]) wr(8'h46, h);
         wr(8'h47, d);
         @(negedge clk_i);
         `CHK("txd_start", !(m[7] && !m[5]), txd_o)
         if (m[7] && !m[5]) begin
            x = {h[0], d};
            if (m[1] && m[4]) x[8] = m[0] ^ (^d);
            else if (m[1]) x[7] = m[0] ^ (^d[6:0]);
         end
         for (i = 0; i < 600 && irq_o !== 1'b1; i++) @(negedge clk_i);
         if (irq_o !== 1'b1) begin
            n_mismatch++;
            report_and_stop;
         end
         // Buffer state, receive full, no framing or parity error
         rd(8'h44, v);
         `CHK("status", {(m[7] && !m[5]), 3'b100}, {v[7], v[5], v[1], v[0]})
         rd(8'h47, v);
         `CHK("rx_low", x[7:0], v)
         rd(8'h46, v);
         `CHK("rx_ninth", (m[4] ? x[8] : 1'b0), v[0])
         `CHK("irq_clear", 1'b0, irq_o)
         repeat (200) @(negedge clk_i); // Line stays high long enough for idle
         rd(8'h44, v);
         `CHK("idle", 1'b1, v[4])
      end
      report_and_stop;
   end
endmodule : uart_frame_loop_irq_control_test
